// ===== design/octet_fifo.sv
// Purpose: small synchronous FIFO for reply octets
// Assumes: DEPTH is a power of two
// Notes:   in_ready low when full, out_valid low when empty
`timescale 1ns/100ps
module octet_fifo #(
  parameter int W     = 9,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst,
  // Fill side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // Drain side
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_q;
  logic [AW:0]  rd_q;
  logic         full;
  logic         empty;

  assign empty     = (wr_q == rd_q);
  assign full      = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_q[AW-1:0]];

  always_ff @(posedge mclk) begin
    if (in_valid && !full) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (in_valid && !full) begin
        wr_q <= wr_q + (AW+1)'(1);
      end
      if (out_ready && !empty) begin
        rd_q <= rd_q + (AW+1)'(1);
      end
    end
  end
endmodule

// ===== design/perf_counters.sv
// Purpose: wrapping performance counters of one side with overflow and reset flags
// Assumes: tick inputs are one-cycle pulses on mclk
// Notes:   a set in the same cycle as a delivery clear wins
`timescale 1ns/100ps
`include "status_poll_map.svh"
module perf_counters (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // Events
  input  wire logic [4:0] tick,
  input  wire logic       clr_counts,
  // Values
  perf_if.cnt             p
);
  logic wrap;

  assign wrap = (tick[`TK_ES] && (&p.es)) || (tick[`TK_SES] && (&p.severely_errored_seconds)) ||
                (tick[`TK_CRC] && (&p.crc)) || (tick[`TK_SYNC_WORD_LOSS] && (&p.sync_word_loss)) ||
                (tick[`TK_UAS] && (&p.unavailable_seconds));

  always_ff @(posedge mclk) begin
    if (rst || clr_counts) begin
      p.es   <= '0;
      p.severely_errored_seconds  <= '0;
      p.crc  <= '0;
      p.sync_word_loss <= '0;
      p.unavailable_seconds  <= '0;
    end else begin
      p.es   <= p.es + 8'(tick[`TK_ES]);
      p.severely_errored_seconds  <= p.severely_errored_seconds + 8'(tick[`TK_SES]);
      p.crc  <= p.crc + 16'(tick[`TK_CRC]);
      p.sync_word_loss <= p.sync_word_loss + 8'(tick[`TK_SYNC_WORD_LOSS]);
      p.unavailable_seconds  <= p.unavailable_seconds + 8'(tick[`TK_UAS]);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      p.ovf_line <= 1'b0;
      p.ovf_cust <= 1'b0;
    end else begin
      p.ovf_line <= wrap || (p.ovf_line && !p.clr_line);
      p.ovf_cust <= wrap || (p.ovf_cust && !p.clr_cust);
    end
  end

  // Power-up counts as a counter reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      p.rst_line <= 1'b1;
      p.rst_cust <= 1'b1;
    end else begin
      p.rst_line <= clr_counts || (p.rst_line && !p.clr_line);
      p.rst_cust <= clr_counts || (p.rst_cust && !p.clr_cust);
    end
  end

  ovf_set_a: assert property (
    @(posedge mclk) disable iff (rst) wrap |=> p.ovf_line && p.ovf_cust)
    else $error("counter wrap did not raise overflow flags");
  line_clear_a: assert property (
    @(posedge mclk) disable iff (rst) p.clr_line && !wrap && !clr_counts |=> !p.ovf_line && !p.rst_line)
    else $error("line-side flags not cleared on delivery");
  cust_clear_a: assert property (
    @(posedge mclk) disable iff (rst) p.clr_cust && !wrap && !clr_counts |=> !p.ovf_cust && !p.rst_cust)
    else $error("customer-side flags not cleared on delivery");
  reset_flag_a: assert property (
    @(posedge mclk) disable iff (rst) clr_counts |=> p.rst_line && p.rst_cust && p.crc == 16'h0000)
    else $error("counter reset not flagged");
endmodule

// ===== design/perf_if.sv
// Purpose: counter values and delivery clears of one side
// Assumes: one clock domain
// Notes:   cnt side owns the counters, rd side reads them
`timescale 1ns/100ps
interface perf_if;
  logic [7:0]  es;
  logic [7:0]  severely_errored_seconds;
  logic [15:0] crc;
  logic [7:0]  sync_word_loss;
  logic [7:0]  unavailable_seconds;
  logic        ovf_line;
  logic        rst_line;
  logic        ovf_cust;
  logic        rst_cust;
  logic        clr_line;
  logic        clr_cust;
  modport cnt (output es, severely_errored_seconds, crc, sync_word_loss, unavailable_seconds, ovf_line, rst_line, ovf_cust, rst_cust,
               input clr_line, clr_cust);
  modport rd  (input es, severely_errored_seconds, crc, sync_word_loss, unavailable_seconds, ovf_line, rst_line, ovf_cust, rst_cust,
               output clr_line, clr_cust);
endinterface

// ===== design/status_poll_map.svh
// Purpose: named numbers for the status poll responder
// Assumes: included by bare name
// Notes:   octet indices count from 0 (octet 1 is index 0)
`ifndef STATUS_POLL_MAP_SVH
`define STATUS_POLL_MAP_SVH
`define ID_POLL      8'h0B
`define ID_FULL_POLL 8'h0C
`define ID_MAINT     8'h89
`define ID_SNR_OK    8'h8B
`define ID_NET_REC   8'h8C
`define ID_CUST_REC  8'h8D
`define ID_REQ_LO    8'h02
`define ID_REQ_HI    8'h0C
`define SNR_NA       8'h7F
`define SNR_MAX      9'sh07E
`define ATT_NA       8'h80
`define SNR_RND      11'sh003
`define SNR_FRAC     2
`define SNR_OK_LEN   4'h4
`define REC_LEN      4'hC
`define MAINT_LEN    4'h1
`define MSG_SNR      0
`define MSG_NET      1
`define MSG_CUST     2
`define MSG_MAINT    3
`define MASK_SNR     4'h1
`define MASK_FULL    4'hE
`define TK_ES        0
`define TK_SES       1
`define TK_CRC       2
`define TK_SYNC_WORD_LOSS      3
`define TK_UAS       4
`define FIFO_W       9
`define FIFO_DEPTH   8
`endif

// ===== design/status_poll_pkg.sv
// Purpose: types shared by the status poll responder
// Assumes: nothing
// Notes:   snr_qdb is quarter-dB fixed point
package status_poll_pkg;
  typedef logic [7:0] octet_t;
  typedef logic [11:0][7:0] msg_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_LOAD = 4'b0010,
    ST_EMIT = 4'b0100
  } state_e;
  typedef struct packed {
    logic               pbo_sel;
    logic               dev_fault;
    logic               dc_fault;
    logic               snr_alarm;
    logic               att_alarm;
    logic               sync_word_loss_fail;
    logic               snr_avail;
    logic signed [9:0]  snr_qdb;
    logic               att_avail;
    logic signed [7:0]  att_db;
    logic [3:0]         pbo_base;
    logic               pbo_ext;
  } side_status_s;
endpackage

// ===== design/status_poll_responder.sv
// Purpose: answers status polls with octet streams of status messages
// Assumes: all inputs come from logic on mclk; requests arrive as single octets
// Notes:   maintenance reply carries its identifier only
`timescale 1ns/100ps
`include "status_poll_map.svh"

module status_poll_responder (
  // Clock and reset
  input  wire logic                          mclk,
  input  wire logic                          rst,
  // Request octets
  input  wire logic                          req_valid,
  input  wire logic [7:0]                    req_octet,
  input  wire logic                          req_from_cust,
  output logic                               req_ready,
  // Configuration
  input  wire logic                          unit_is_line_side,
  input  wire logic                          cust_flow_disabled,
  input  wire logic [1:0]                    loop_id,
  // Line status
  input  wire status_poll_pkg::side_status_s net_status,
  input  wire status_poll_pkg::side_status_s cust_status,
  input  wire logic                          maint_active,
  input  wire logic [4:0]                    net_ticks,
  input  wire logic [4:0]                    cust_ticks,
  input  wire logic                          counters_reset,
  // Reply octets
  output logic                               tx_valid,
  output logic [7:0]                         tx_octet,
  output logic                               tx_last,
  input  wire logic                          tx_ready
);
  import status_poll_pkg::*;

  state_e                   state_q;
  logic [3:0]               pend_q;
  logic [3:0]               idx_q;
  logic [3:0]               len_q;
  msg_t                     out_q;
  logic                     from_cust_q;
  logic                     req_ready_q;
  logic                     tx_valid_q;
  logic [7:0]               tx_octet_q;
  logic                     tx_last_q;
  side_status_s             st [2];
  logic [4:0]               ticks [2];
  msg_t                     rec [2];
  msg_t                     snap_q [2];
  msg_t                     snr_msg;
  logic [1:0]               alarm;
  logic [1:0]               changed;
  logic [1:0]               hit;
  logic [1:0]               sel;
  logic                     take;
  logic                     is_poll;
  logic                     is_full;
  logic                     suppress;
  logic                     take_poll;
  logic                     push;
  logic                     at_end;
  logic                     fifo_in_ready;
  logic                     fifo_out_valid;
  logic [`FIFO_W-1:0]       fifo_in_data;
  logic [`FIFO_W-1:0]       fifo_out_data;
  logic                     fifo_out_ready;

  function automatic octet_t snr_rnd(input logic avail, input logic signed [9:0] q);
    logic signed [10:0] s;
    logic signed [8:0]  r;
    s = {q[9], q} + `SNR_RND;
    r = 9'(s >>> `SNR_FRAC);
    if (!avail) begin
      return `SNR_NA;
    end
    if (r > `SNR_MAX) begin
      r = `SNR_MAX;
    end
    return r[7:0];
  endfunction

  assign st[0]    = net_status;
  assign st[1]    = cust_status;
  assign ticks[0] = net_ticks;
  assign ticks[1] = cust_ticks;

  perf_if pf [2] ();

  for (genvar g = 0; g < 2; g++) begin : g_side
    perf_counters u_cnt (
      .mclk       (mclk),
      .rst        (rst),
      .tick       (ticks[g]),
      .clr_counts (counters_reset),
      .p          (pf[g])
    );

    // Delivery clear acts in the capture cycle so a same-cycle wrap survives
    assign pf[g].clr_line = sel[g] && !from_cust_q;
    assign pf[g].clr_cust = sel[g] && from_cust_q;

    always_comb begin
      rec[g][0]  = (g == 0) ? `ID_NET_REC : `ID_CUST_REC;
      rec[g][1]  = {1'b0, st[g].pbo_sel, st[g].dev_fault, st[g].dc_fault,
                    st[g].snr_alarm, st[g].att_alarm, st[g].sync_word_loss_fail, 1'b0};
      rec[g][2]  = snr_rnd(st[g].snr_avail, st[g].snr_qdb);
      rec[g][3]  = st[g].att_avail ? st[g].att_db : `ATT_NA;
      rec[g][4]  = pf[g].es;
      rec[g][5]  = pf[g].severely_errored_seconds;
      rec[g][6]  = pf[g].crc[15:8];
      rec[g][7]  = pf[g].crc[7:0];
      rec[g][8]  = pf[g].sync_word_loss;
      rec[g][9]  = pf[g].unavailable_seconds;
      rec[g][10] = {pf[g].ovf_line, pf[g].rst_line, pf[g].ovf_cust, pf[g].rst_cust,
                    st[g].pbo_base};
      rec[g][11] = {st[g].pbo_ext, 5'h00, loop_id};
    end

    assign alarm[g]   = |rec[g][1][5:1];
    // SNR octet left out of the comparison
    assign changed[g] = {rec[g][11:3], rec[g][1:0]} != {snap_q[g][11:3], snap_q[g][1:0]};
  end

  always_comb begin
    snr_msg    = '0;
    snr_msg[0] = `ID_SNR_OK;
    snr_msg[1] = unit_is_line_side ? 8'h00 : rec[0][2];
    snr_msg[2] = unit_is_line_side ? rec[1][2] : 8'h00;
    snr_msg[3] = {6'h00, loop_id};
  end

  assign take      = req_valid && req_ready_q;
  assign is_poll   = (req_octet == `ID_POLL);
  assign is_full   = (req_octet == `ID_FULL_POLL);
  assign suppress  = !unit_is_line_side && cust_flow_disabled && req_from_cust &&
                     (req_octet >= `ID_REQ_LO) && (req_octet <= `ID_REQ_HI);
  assign take_poll = take && (is_poll || is_full) && !suppress;
  assign hit       = alarm | changed;
  assign sel[0]    = (state_q == ST_LOAD) && !pend_q[`MSG_SNR] && pend_q[`MSG_NET];
  assign sel[1]    = (state_q == ST_LOAD) && !pend_q[`MSG_SNR] && !pend_q[`MSG_NET] && pend_q[`MSG_CUST];
  assign push      = (state_q == ST_EMIT) && fifo_in_ready;
  assign at_end    = (idx_q == len_q - 4'h1);
  assign fifo_in_data = {at_end, out_q[idx_q]};

  // Sequencer
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q     <= ST_IDLE;
      pend_q      <= '0;
      idx_q       <= '0;
      from_cust_q <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (take_poll) begin
            from_cust_q <= req_from_cust;
            state_q     <= ST_LOAD;
            if (is_full) begin
              pend_q <= `MASK_FULL;
            end else if ((|hit) || maint_active) begin
              pend_q <= {maint_active, hit, 1'b0};
            end else begin
              pend_q <= `MASK_SNR;
            end
          end
        end
        ST_LOAD: begin
          pend_q  <= pend_q & (pend_q - 4'h1);
          idx_q   <= '0;
          state_q <= ST_EMIT;
        end
        ST_EMIT: begin
          if (push) begin
            idx_q <= idx_q + 4'h1;
            if (at_end) begin
              state_q <= (pend_q == '0) ? ST_IDLE : ST_LOAD;
            end
          end
        end
      endcase
    end
  end

  // Message capture
  always_ff @(posedge mclk) begin
    if (rst) begin
      out_q <= '0;
      len_q <= `MAINT_LEN;
    end else if (state_q == ST_LOAD) begin
      if (pend_q[`MSG_SNR]) begin
        out_q <= snr_msg;
        len_q <= `SNR_OK_LEN;
      end else if (sel[0] || sel[1]) begin
        out_q <= sel[0] ? rec[0] : rec[1];
        len_q <= `REC_LEN;
      end else begin
        out_q    <= '0;
        out_q[0] <= `ID_MAINT;
        len_q    <= `MAINT_LEN;
      end
    end
  end

  // Last reported values
  always_ff @(posedge mclk) begin
    if (rst) begin
      snap_q[0] <= '0;
      snap_q[1] <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (sel[i]) begin
          snap_q[i] <= rec[i];
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      req_ready_q <= 1'b1;
    end else if (take_poll) begin
      req_ready_q <= 1'b0;
    end else if (push && at_end && pend_q == '0) begin
      req_ready_q <= 1'b1;
    end
  end

  octet_fifo #(
    .W     (`FIFO_W),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .rst       (rst),
    .in_valid  (state_q == ST_EMIT),
    .in_data   (fifo_in_data),
    .in_ready  (fifo_in_ready),
    .out_valid (fifo_out_valid),
    .out_data  (fifo_out_data),
    .out_ready (fifo_out_ready)
  );

  // Output register stage
  assign fifo_out_ready = !tx_valid_q || tx_ready;

  always_ff @(posedge mclk) begin
    if (rst) begin
      tx_valid_q <= 1'b0;
      tx_octet_q <= 8'h00;
      tx_last_q  <= 1'b0;
    end else if (fifo_out_ready) begin
      tx_valid_q <= fifo_out_valid;
      if (fifo_out_valid) begin
        tx_octet_q <= fifo_out_data[7:0];
        tx_last_q  <= fifo_out_data[8];
      end
    end
  end

  assign req_ready = req_ready_q;
  assign tx_valid  = tx_valid_q;
  assign tx_octet  = tx_octet_q;
  assign tx_last   = tx_last_q;

  quiet_poll_a: assert property (
    @(posedge mclk) disable iff (rst)
    take_poll && is_poll && hit == 2'b00 && !maint_active |=> pend_q == `MASK_SNR ##1 out_q[0] == `ID_SNR_OK)
    else $error("quiet poll not answered by snr reply");
  full_poll_a: assert property (
    @(posedge mclk) disable iff (rst)
    take_poll && is_full |=> pend_q == `MASK_FULL ##1 out_q[0] == `ID_NET_REC && len_q == `REC_LEN)
    else $error("full poll did not start with network record");
  alarm_reply_a: assert property (
    @(posedge mclk) disable iff (rst) take_poll && is_poll && alarm[1] |=> pend_q[`MSG_CUST] && !pend_q[`MSG_SNR])
    else $error("active customer alarm not reported");
  change_reply_a: assert property (
    @(posedge mclk) disable iff (rst) take_poll && is_poll && changed[0] |=> pend_q[`MSG_NET])
    else $error("changed network values not reported");
  flow_block_a: assert property (
    @(posedge mclk) disable iff (rst) take && suppress |=> state_q == ST_IDLE && req_ready_q)
    else $error("request served while customer flow disabled");
  octet_order_a: assert property (
    @(posedge mclk) disable iff (rst) push && !at_end |=> idx_q == $past(idx_q) + 4'h1)
    else $error("reply octets skipped or repeated");
  rec_reserved_a: assert property (
    @(posedge mclk) disable iff (rst)
    state_q == ST_EMIT && len_q == `REC_LEN |-> out_q[1][7] == 1'b0 && out_q[1][0] == 1'b0 && out_q[11][6:2] == 5'h00)
    else $error("reserved record bits not zero");
  snr_side_a: assert property (
    @(posedge mclk) disable iff (rst)
    state_q == ST_LOAD && pend_q[`MSG_SNR] && unit_is_line_side |=> out_q[1] == 8'h00 && len_q == `SNR_OK_LEN)
    else $error("own-segment network margin not zero");
  snap_keep_a: assert property (
    @(posedge mclk) disable iff (rst) sel[0] |=> !changed[0] || $changed(rec[0]))
    else $error("snapshot not taken on delivery");

  quiet_poll_c: cover property (@(posedge mclk) disable iff (rst) take_poll && pend_q == '0 ##1 pend_q == `MASK_SNR);
  full_poll_c: cover property (@(posedge mclk) disable iff (rst) take_poll && is_full);
  two_rec_c: cover property (@(posedge mclk) disable iff (rst) take_poll && is_poll && hit == 2'b11);
  stall_c: cover property (@(posedge mclk) disable iff (rst) state_q == ST_EMIT && !fifo_in_ready);
endmodule

// ===== tb/mgmt_master_model.sv
// Purpose: management master model, sends request octets and sinks reply octets
// Assumes: one request outstanding at a time
// Notes:   stall holds off the reply sink; received octets kept with tx_last
`timescale 1ns/100ps
module mgmt_master_model (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // Bench control
  input  wire logic       go,
  input  wire logic [7:0] go_id,
  input  wire logic       go_cust,
  input  wire logic       stall,
  // Request side
  output logic            req_valid,
  output logic [7:0]      req_octet,
  output logic            req_from_cust,
  input  wire logic       req_ready,
  // Reply side
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_octet,
  input  wire logic       tx_last,
  output logic            tx_ready
);
  logic [8:0] rx_q[$];
  assign tx_ready = !stall;
  always @(posedge mclk) begin
    if (rst) begin
      req_valid <= 1'b0;
      req_octet <= 8'h00;
      req_from_cust <= 1'b0;
    end else if (go) begin
      req_valid <= 1'b1;
      req_octet <= go_id;
      req_from_cust <= go_cust;
    end else if (req_valid && req_ready) begin
      req_valid <= 1'b0;
      // Released octet no longer shows the old value
      req_octet <= ~req_octet;
    end
    if (tx_valid && tx_ready) begin
      rx_q.push_back({tx_last, tx_octet});
    end
  end
endmodule

// ===== tb/tb_top.sv
// Purpose: self-checking bench for the status poll responder
// Assumes: fixed LFSR seed, inputs driven 1 ns after the rising edge
// Notes:   expected replies built by bench functions
`timescale 1ns/100ps
`include "status_poll_map.svh"
module tb_top;
  import status_poll_pkg::*;
  logic mclk, rst, go, go_cust, stall, req_valid, req_from_cust, req_ready, tx_valid, tx_last, tx_ready;
  logic unit_is_line_side, cust_flow_disabled, maint_active, counters_reset;
  logic [7:0] go_id, req_octet, tx_octet, v8;
  logic [1:0] loop_id;
  logic [4:0] net_ticks, cust_ticks;
  logic [31:0] lfsr, v;
  side_status_s net_status, cust_status;
  int n_mismatch, n_compared, cyc;
  logic [15:0] cnt[2][5];
  logic [3:0] flg[2];
  logic [8:0] exp_q[$];

  status_poll_responder status_poll_responder_inst (.mclk, .rst, .req_valid, .req_octet, .req_from_cust,
    .req_ready, .unit_is_line_side, .cust_flow_disabled, .loop_id, .net_status, .cust_status, .maint_active,
    .net_ticks, .cust_ticks, .counters_reset, .tx_valid, .tx_octet, .tx_last, .tx_ready);
  mgmt_master_model mgmt_master_model_inst (.mclk, .rst, .go, .go_id, .go_cust, .stall, .req_valid,
    .req_octet, .req_from_cust, .req_ready, .tx_valid, .tx_octet, .tx_last, .tx_ready);

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  function automatic side_status_s quiet();
    logic [31:0] r;
    side_status_s s;
    r = rnd();
    s = r[$bits(side_status_s)-1:0];
    {s.dev_fault, s.dc_fault, s.snr_alarm, s.att_alarm, s.sync_word_loss_fail} = 5'h00;
    return s;
  endfunction

  // Margin rounded up to whole dB, saturated below the not-available code
  function automatic octet_t mar(side_status_s s);
    int r;
    r = (int'(s.snr_qdb) + 3) >>> 2;
    if (r > 126) r = 126;
    return s.snr_avail ? octet_t'(r[7:0]) : `SNR_NA;
  endfunction

  task automatic add_rec(input octet_t id, input side_status_s s, input int k, input logic c);
    octet_t o[12];
    o[0] = id;
    o[1] = {1'b0, s.pbo_sel, s.dev_fault, s.dc_fault, s.snr_alarm, s.att_alarm, s.sync_word_loss_fail, 1'b0};
    o[2] = mar(s);
    o[3] = s.att_avail ? s.att_db : `ATT_NA;
    o[4] = cnt[k][0][7:0];
    o[5] = cnt[k][1][7:0];
    o[6] = cnt[k][2][15:8];
    o[7] = cnt[k][2][7:0];
    o[8] = cnt[k][3][7:0];
    o[9] = cnt[k][4][7:0];
    o[10] = {flg[k], s.pbo_base};
    o[11] = {s.pbo_ext, 5'h00, loop_id};
    for (int i = 0; i < 12; i++) exp_q.push_back({i == 11, o[i]});
    if (c) flg[k][1:0] = 2'h0;
    else flg[k][3:2] = 2'h0;
  endtask

  task automatic tick(input int k, input logic [4:0] m);
    @(posedge mclk);
    #1;
    if (k == 0) net_ticks = m;
    else cust_ticks = m;
    for (int i = 0; i < 5; i++) if (m[i]) begin
      if (cnt[k][i] == ((i == 2) ? 16'hFFFF : 16'h00FF)) flg[k] = flg[k] | 4'hA;
      cnt[k][i] = (i == 2) ? cnt[k][i] + 16'h0001 : {8'h00, cnt[k][i][7:0] + 8'h01};
    end
    @(posedge mclk);
    #1;
    net_ticks = 5'h00;
    cust_ticks = 5'h00;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic poll(input octet_t id, input logic c);
    int w;
    mgmt_master_model_inst.rx_q.delete();
    @(posedge mclk);
    #1;
    go = 1'b1;
    go_id = id;
    go_cust = c;
    @(posedge mclk);
    #1;
    go = 1'b0;
    w = 0;
    while (mgmt_master_model_inst.rx_q.size() < exp_q.size() && w < 400) begin
      @(posedge mclk);
      w++;
    end
    repeat (30) @(posedge mclk);
    #1;
    chk("reply length", exp_q.size(), mgmt_master_model_inst.rx_q.size());
    for (int i = 0; i < exp_q.size(); i++) chk("reply octet", exp_q[i], mgmt_master_model_inst.rx_q[i]);
    chk("req_ready", 16'h0001, {15'h0000, req_ready});
    exp_q.delete();
  endtask

  task automatic full(input logic c);
    add_rec(`ID_NET_REC, net_status, 0, c);
    add_rec(`ID_CUST_REC, cust_status, 1, c);
    exp_q.push_back({1'b1, `ID_MAINT});
    poll(`ID_FULL_POLL, c);
  endtask

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    #1;
    cyc++;
    stall = rnd() < 32'h60000000;
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  initial begin
    lfsr = 32'h30296CF0;
    {rst, stall, go, go_cust, go_id, maint_active, counters_reset} = {2'b11, 12'h000};
    {unit_is_line_side, cust_flow_disabled, loop_id, net_ticks, cust_ticks} = {1'b1, 1'b0, 2'h2, 10'h000};
    net_status = quiet();
    cust_status = quiet();
    foreach (cnt[k, i]) cnt[k][i] = 16'h0000;
    flg[0] = 4'h5;
    flg[1] = 4'h5;
    repeat (2) @(posedge mclk);
    #1;
    rst = 1'b0;
    full(1'b0);
    full(1'b1);
    // Loop number is a record field, so change it before the snapshot
    loop_id = 2'h1;
    full(1'b0);
    for (int u = 0; u < 2; u++) begin
      unit_is_line_side = u[0];
      v = rnd();
      {net_status.snr_avail, net_status.snr_qdb} = v[10:0];
      {cust_status.snr_avail, cust_status.snr_qdb} = v[21:11];
      exp_q = '{{1'b0, `ID_SNR_OK}, {1'b0, u[0] ? 8'h00 : mar(net_status)},
                {1'b0, u[0] ? mar(cust_status) : 8'h00}, {1'b1, 6'h00, loop_id}};
      poll(`ID_POLL, 1'b0);
    end
    repeat (257) tick(0, 5'h01);
    repeat (30) begin
      v = rnd();
      tick(0, v[4:0]);
    end
    add_rec(`ID_NET_REC, net_status, 0, 1'b1);
    poll(`ID_POLL, 1'b1);
    net_status.att_db = (net_status.att_avail && net_status.att_db == 8'h11) ? 8'h22 : 8'h11;
    net_status.att_avail = 1'b1;
    cust_status.sync_word_loss_fail = 1'b1;
    maint_active = 1'b1;
    add_rec(`ID_NET_REC, net_status, 0, 1'b0);
    add_rec(`ID_CUST_REC, cust_status, 1, 1'b0);
    exp_q.push_back({1'b1, `ID_MAINT});
    poll(`ID_POLL, 1'b0);
    repeat (3) begin
      v = rnd();
      v8 = (v[7:0] == 8'h0B || v[7:0] == 8'h0C) ? 8'h20 : v[7:0];
      poll(v8, 1'b0);
    end
    // Counter reset pulse, then customer-side events
    @(posedge mclk);
    #1;
    counters_reset = 1'b1;
    foreach (cnt[k, i]) cnt[k][i] = 16'h0000;
    flg[0] = flg[0] | 4'h5;
    flg[1] = flg[1] | 4'h5;
    @(posedge mclk);
    #1;
    counters_reset = 1'b0;
    repeat (5) begin
      v = rnd();
      tick(1, v[4:0]);
    end
    add_rec(`ID_NET_REC, net_status, 0, 1'b1);
    add_rec(`ID_CUST_REC, cust_status, 1, 1'b1);
    exp_q.push_back({1'b1, `ID_MAINT});
    poll(`ID_POLL, 1'b1);
    unit_is_line_side = 1'b0;
    cust_flow_disabled = 1'b1;
    poll(`ID_POLL, 1'b1);
    poll(`ID_FULL_POLL, 1'b1);
    report_and_stop();
  end
endmodule
